// ---- design/cmo_pkg.sv ----
// ============
// shared constants and types for the message object access block
// ============
package cmo_pkg;

  // ============
  // clock and timing
  // ============
  localparam int CLK_PERIOD_NS = 5;
  localparam int CAN_RST_NS    = 1000;   // controller reset pulse width
  localparam int CAN_RST_CYC   = (CAN_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CAN_RST_CNT = 8'(CAN_RST_CYC - 1);

  // ============
  // message objects and identifiers
  // ============
  localparam logic [3:0]  OBJ_MIN     = 4'h1;
  localparam logic [3:0]  OBJ_RX_MAX  = 4'hF;
  localparam logic [3:0]  OBJ_TX_MAX  = 4'hE;
  localparam int          ID_W        = 29;
  localparam logic [28:0] ID_STD_MASK = 29'h00007FF;
  localparam logic [28:0] ID_EXT_MASK = 29'h1FFFFFFF;
  localparam logic [28:0] FILT_RST    = 29'h1FFFFFFF;  // every bit must match
  localparam logic [31:0] NO_MSG      = 32'hFFFFFFFF;  // -1
  localparam logic [3:0]  DLC_MAX     = 4'h8;
  localparam logic [3:0]  BUF_CNT_IDX = 4'h9;          // element holding byte count
  localparam logic [3:0]  STREAM_LAST = 4'h8;          // zero-based last element

  // ============
  // controller register numbers and init table
  // ============
  localparam logic [7:0] REG_FILT_0   = 8'h06;
  localparam logic [7:0] REG_FILT_1   = 8'h07;
  localparam logic [7:0] REG_FILT_2   = 8'h08;
  localparam logic [7:0] REG_FILT_3   = 8'h09;
  localparam logic [7:0] REG_CLKOUT   = 8'h1F;
  localparam logic [7:0] REG_BUSCFG   = 8'h2F;
  localparam logic [7:0] REG_BITT_0   = 8'h3F;
  localparam logic [7:0] REG_BITT_1   = 8'h4F;
  localparam logic [7:0] BITT_0_1M    = 8'h00;  // 1 Mbit/s timing, low byte
  localparam logic [7:0] BITT_1_1M    = 8'h14;  // 1 Mbit/s timing, high byte
  localparam int         CFG_N        = 8;
  localparam logic [2:0] CFG_LAST     = 3'(CFG_N - 1);
  localparam logic [7:0] CFG_ADDR [CFG_N] = '{REG_FILT_0, REG_FILT_1, REG_FILT_2, REG_FILT_3,
                                              REG_CLKOUT, REG_BUSCFG, REG_BITT_0, REG_BITT_1};
  localparam logic [7:0] CFG_DATA [CFG_N] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                              8'h00, 8'h00, BITT_0_1M, BITT_1_1M};

  // ============
  // data path buffering
  // ============
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;

  // ============
  // host commands and control states
  // ============
  typedef enum logic [3:0] {
    OP_EN_RX    = 4'h0,
    OP_EN_TX    = 4'h1,
    OP_EN_EVT   = 4'h2,
    OP_GET_REG  = 4'h3,
    OP_SET_REG  = 4'h4,
    OP_INIT     = 4'h5,
    OP_READ     = 4'h6,
    OP_READ_CON = 4'h7,
    OP_TRANSMIT = 4'h8
  } cmo_op_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_RST    = 5'h02,
    ST_CFG    = 5'h04,
    ST_STREAM = 5'h08,
    ST_RESP   = 5'h10
  } cmo_state_t;

endpackage

// ---- design/cmo_fifo.sv ----
// ============
// byte fifo with registered output stage
// ============
module cmo_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          wr;
  logic          rd;

  // ============
  // handshakes; the output stage refills whenever it empties or is taken
  // ============
  assign in_ready = (cnt_r != FULL);
  assign wr       = in_valid && in_ready;
  assign rd       = (cnt_r != '0) && (!out_valid || out_ready);

  // storage, pointers and output stage
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_r] <= in_data;
    end
    if (rst) begin
      wp_r      <= '0;
      rp_r      <= '0;
      cnt_r     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (wr) wp_r <= wp_r + 1'b1;
      if (rd) begin
        rp_r     <= rp_r + 1'b1;
        out_data <= mem[rp_r];
      end
      cnt_r     <= cnt_r + CW'(wr) - CW'(rd);
      out_valid <= rd || (out_valid && !out_ready);
    end
  end

endmodule

// ---- design/cmo_access.sv ----
// Operation
// - frame stored in an event-enabled object 1..15 pulses the event output
// - objects 1..15 take bus frames only after receive enable
// - receive object stores only frames whose identifier equals its own
// - per-object length select: 0 gives 11-bit, 1 gives 29-bit identifier
// - objects 1..14 send frames only after transmit enable
// - sent frames carry the identifier programmed at transmit enable
// - registers 0..255 are addressed by number; reads return contents
// - register read value sits in the low eight bits of the answer
// - init first holds the controller in hardware reset
// - init sets all acceptance filters to every bit must match
// - init writes zero to clock-output and bus-configuration registers
// - init programs bit timing for 1 Mbit/s
// - init ends with every object disabled for receive and transmit
// - plain read answers -1 when no new message is present
// - new message: data bytes and byte count go out on the message byte stream, identifier is answered
// - reading clears the new-message flag until the next frame arrives
// - consistent read delivers bytes from exactly one frame
// - host buffer is nine bytes: eight data, then byte count 0..8
// - a transmit request is sent once the object wins bus access
module cmo_access (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // host command port
  input  wire logic             cmd_valid,
  input  cmo_pkg::cmo_op_t      cmd_op,
  input  wire logic [3:0]       cmd_obj,
  input  wire logic [28:0]      cmd_id,
  input  wire logic             identifier_length_select,
  input  wire logic [7:0]       cmd_reg,
  input  wire logic [7:0]       cmd_wdata,
  output logic                  cmd_ready,
  // host answer
  output logic                  rsp_valid,
  output logic [31:0]           rsp_data,
  // host message buffer write
  input  wire logic             buf_wr,
  input  wire logic [3:0]       buf_idx,
  input  wire logic [7:0]       buf_wdata,
  // received message byte stream
  output logic                  msg_valid,
  output logic [7:0]            msg_data,
  input  wire logic             msg_ready,
  // bus side receive, from the protocol engine on clk
  input  wire logic             rx_valid,
  input  wire logic [28:0]      rx_id,
  input  wire logic             rx_ext,
  input  wire logic [3:0]       rx_dlc,
  input  wire logic [63:0]      rx_data,
  // bus side transmit
  output logic                  tx_req,
  output logic [3:0]            tx_obj,
  output logic [28:0]           tx_id,
  output logic                  tx_ext,
  output logic [3:0]            tx_dlc,
  output logic [63:0]           tx_data,
  input  wire logic             tx_done,
  // controller side effects
  output logic                  can_rst,
  output logic                  msg_event
);
  import cmo_pkg::*;

  // ========================================================================
  // state
  // ========================================================================
  cmo_state_t  st_r;
  logic [7:0]  rcnt_r;
  logic [2:0]  cfg_r;
  logic [3:0]  idx_r;
  logic [3:0]  rd_obj_r;
  logic        con_r;
  logic [28:0] filt_r;
  logic [7:0]  reg_mem [256];
  logic [63:0] hbuf_data_r;
  logic [3:0]  hbuf_cnt_r;
  logic [63:0] sh_data_r;
  logic [3:0]  sh_dlc_r;
  logic [28:0] sh_id_r;

  // per-object storage
  logic [15:1] rx_en_r;
  logic [15:1] tx_en_r;
  logic [15:1] evt_en_r;
  logic [15:1] ext_r;
  logic [15:1] new_r;
  logic [15:1] pend_r;
  logic [28:0] id_r    [1:15];
  logic [28:0] rid_r   [1:15];
  logic [63:0] data_r  [1:15];
  logic [3:0]  dlc_r   [1:15];
  logic [63:0] txd_r   [1:15];
  logic [3:0]  txdlc_r [1:15];

  // ========================================================================
  // command decode
  // ========================================================================
  wire take      = cmd_valid && cmd_ready && (st_r == ST_IDLE);
  wire obj_rx_ok = (cmd_obj >= OBJ_MIN) && (cmd_obj <= OBJ_RX_MAX);
  wire obj_tx_ok = (cmd_obj >= OBJ_MIN) && (cmd_obj <= OBJ_TX_MAX);
  wire do_en_rx  = take && (cmd_op == OP_EN_RX) && obj_rx_ok;
  wire do_en_tx  = take && (cmd_op == OP_EN_TX) && obj_tx_ok;
  wire do_en_evt = take && (cmd_op == OP_EN_EVT) && obj_rx_ok;
  wire do_set    = take && (cmd_op == OP_SET_REG);
  wire do_init   = take && (cmd_op == OP_INIT);
  wire is_read   = (cmd_op == OP_READ) || (cmd_op == OP_READ_CON);
  wire do_read   = take && is_read && obj_rx_ok && new_r[cmd_obj];
  wire do_xmit   = take && (cmd_op == OP_TRANSMIT) && obj_tx_ok && tx_en_r[cmd_obj];
  wire clr_all   = (st_r == ST_CFG) && (cfg_r == CFG_LAST);
  wire [15:1] obj_sel = 15'(16'h0001 << cmd_obj >> 1);

  // identifier of a frame, cut to the object's length
  wire [28:0] cmd_id_cut = cmd_id & (identifier_length_select ? ID_EXT_MASK : ID_STD_MASK);

  // ========================================================================
  // host buffer: elements 1..8 are data bytes, element 9 the count
  // ========================================================================
  wire [3:0] hbuf_cnt_cl = (hbuf_cnt_r > DLC_MAX) ? DLC_MAX : hbuf_cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      hbuf_data_r <= '0;
      hbuf_cnt_r  <= '0;
    end else if (buf_wr && (buf_idx == BUF_CNT_IDX)) begin
      hbuf_cnt_r <= buf_wdata[3:0];
    end else if (buf_wr && (buf_idx >= OBJ_MIN) && (buf_idx <= DLC_MAX)) begin
      hbuf_data_r[{buf_idx[2:0] - 3'h1, 3'h0} +: 8] <= buf_wdata;
    end
  end

  // ========================================================================
  // controller register file: init table writes win over host writes
  // ========================================================================
  wire       reg_we    = (st_r == ST_CFG) || do_set;
  wire [7:0] reg_waddr = (st_r == ST_CFG) ? CFG_ADDR[cfg_r] : cmd_reg;
  wire [7:0] reg_wdata = (st_r == ST_CFG) ? CFG_DATA[cfg_r] : cmd_wdata;

  always_ff @(posedge clk) begin
    if (reg_we) reg_mem[reg_waddr] <= reg_wdata;
  end

  // ========================================================================
  // message objects
  // ========================================================================
  logic [15:1] hit;

  genvar gi;
  generate
    for (gi = 1; gi <= 15; gi++) begin : g_obj
      wire [28:0] cmp_mask = filt_r & (ext_r[gi] ? ID_EXT_MASK : ID_STD_MASK);
      // frames match on enable, length and every filtered identifier bit
      assign hit[gi] = rx_valid && rx_en_r[gi] && (rx_ext == ext_r[gi])
                       && (((rx_id ^ id_r[gi]) & cmp_mask) == '0);
      wire rd_clr = do_read && obj_sel[gi];
      wire launch = tx_done && tx_req && (tx_obj == 4'(gi));

      always_ff @(posedge clk) begin
        if (rst || clr_all) begin
          rx_en_r[gi]  <= 1'b0;
          tx_en_r[gi]  <= 1'b0;
          evt_en_r[gi] <= 1'b0;
          ext_r[gi]    <= 1'b0;
          new_r[gi]    <= 1'b0;
          pend_r[gi]   <= 1'b0;
          id_r[gi]     <= '0;
        end else begin
          if ((do_en_rx || do_en_tx) && obj_sel[gi]) begin
            rx_en_r[gi] <= do_en_rx;
            tx_en_r[gi] <= do_en_tx;
            ext_r[gi]   <= identifier_length_select;
            id_r[gi]    <= cmd_id_cut;
          end
          if (do_en_evt && obj_sel[gi]) evt_en_r[gi] <= 1'b1;
          // arrival beats a read clearing the flag in the same cycle
          new_r[gi]  <= hit[gi] || (new_r[gi] && !rd_clr);
          // a new request beats completion of the previous one
          pend_r[gi] <= (do_xmit && obj_sel[gi]) || (pend_r[gi] && !launch);
        end
        if (hit[gi]) begin
          data_r[gi] <= rx_data;
          dlc_r[gi]  <= rx_dlc;
          rid_r[gi]  <= rx_id;
        end
        if (do_xmit && obj_sel[gi]) begin
          txd_r[gi]   <= hbuf_data_r;
          txdlc_r[gi] <= hbuf_cnt_cl;
        end
      end
    end
  endgenerate

  // ========================================================================
  // transmit arbitration: lowest pending object goes first
  // ========================================================================
  logic [3:0] pick;
  always_comb begin
    pick = '0;
    for (int k = 14; k >= 1; k--) begin
      if (pend_r[k] && tx_en_r[k]) pick = 4'(k);
    end
  end
  wire tx_load = !tx_req && (pick != '0);

  always_ff @(posedge clk) begin
    if (rst || clr_all) begin
      tx_req <= 1'b0;
    end else if (tx_load) begin
      tx_req <= 1'b1;
    end else if (tx_done) begin
      tx_req <= 1'b0;
    end
  end

  // frame fields are captured at launch and held until done
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_obj  <= '0;
      tx_id   <= '0;
      tx_ext  <= 1'b0;
      tx_dlc  <= '0;
      tx_data <= '0;
    end else if (tx_load) begin
      tx_obj  <= pick;
      tx_id   <= id_r[pick];
      tx_ext  <= ext_r[pick];
      tx_dlc  <= txdlc_r[pick];
      tx_data <= txd_r[pick];
    end
  end

  // ========================================================================
  // read-out stream: consistent reads use a snapshot taken with the clear;
  // plain reads look at live storage, so a frame landing mid-read can mix
  // ========================================================================
  wire [63:0] src_word = con_r ? sh_data_r : data_r[rd_obj_r];
  wire [3:0]  src_cnt  = con_r ? sh_dlc_r : dlc_r[rd_obj_r];
  wire [28:0] src_id   = con_r ? sh_id_r : rid_r[rd_obj_r];
  wire [7:0]  src_byte = src_word[{idx_r[2:0], 3'h0} +: 8];
  wire [7:0]  push_byte = (idx_r == STREAM_LAST) ? {4'h0, src_cnt} : src_byte;
  wire        push_vld  = (st_r == ST_STREAM);
  wire        push_rdy;
  wire        push_ok   = push_vld && push_rdy;

  cmo_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_vld),
    .in_data   (push_byte),
    .in_ready  (push_rdy),
    .out_valid (msg_valid),
    .out_data  (msg_data),
    .out_ready (msg_ready)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_obj_r  <= '0;
      con_r     <= 1'b0;
      sh_data_r <= '0;
      sh_dlc_r  <= '0;
      sh_id_r   <= '0;
    end else if (do_read) begin
      rd_obj_r  <= cmd_obj;
      con_r     <= (cmd_op == OP_READ_CON);
      sh_data_r <= data_r[cmd_obj];
      sh_dlc_r  <= dlc_r[cmd_obj];
      sh_id_r   <= rid_r[cmd_obj];
    end
  end

  // ========================================================================
  // control sequencer
  // ========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= ST_IDLE;
      rcnt_r <= '0;
      cfg_r  <= '0;
      idx_r  <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          idx_r <= '0;
          if (do_init) begin
            st_r   <= ST_RST;
            rcnt_r <= CAN_RST_CNT;
          end else if (do_read) begin
            st_r <= ST_STREAM;
          end
        end
        ST_RST: begin
          cfg_r  <= '0;
          rcnt_r <= rcnt_r - 8'h01;
          if (rcnt_r == '0) st_r <= ST_CFG;
        end
        ST_CFG: begin
          cfg_r <= cfg_r + 3'h1;
          if (clr_all) st_r <= ST_IDLE;
        end
        ST_STREAM: begin
          if (push_ok) begin
            idx_r <= idx_r + 4'h1;
            if (idx_r == STREAM_LAST) st_r <= ST_RESP;
          end
        end
        ST_RESP: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // controller reset line, the filter mask and the ready flag
  always_ff @(posedge clk) begin
    if (rst) begin
      can_rst   <= 1'b0;
      filt_r    <= FILT_RST;
      cmd_ready <= 1'b1;
    end else begin
      can_rst   <= do_init || ((st_r == ST_RST) && (rcnt_r != '0));
      if (clr_all) filt_r <= FILT_RST;
      cmd_ready <= (st_r == ST_IDLE) ? !(do_init || do_read) : (clr_all || (st_r == ST_RESP));
    end
  end

  // ========================================================================
  // answers and event
  // ========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      msg_event <= 1'b0;
    end else begin
      msg_event <= |(hit & evt_en_r);
      rsp_valid <= (take && !do_init && !do_read) || clr_all || (st_r == ST_RESP);
      if (st_r == ST_RESP) begin
        rsp_data <= {3'h0, src_id};
      end else if (take && (cmd_op == OP_GET_REG)) begin
        rsp_data <= {24'h0, reg_mem[cmd_reg]};
      end else if (take && is_read) begin
        rsp_data <= NO_MSG;
      end else begin
        rsp_data <= '0;
      end
    end
  end

endmodule

// ---- testbench/cmo_access_sva.sv ----
// ============
// port checker for the message object access block
// ============
module cmo_access_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // host side
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input cmo_pkg::cmo_op_t cmd_op,
  input wire logic [3:0]  cmd_obj,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data,
  // bus and controller side
  input wire logic        rx_valid,
  input wire logic        tx_req,
  input wire logic [28:0] tx_id,
  input wire logic        tx_ext,
  input wire logic [63:0] tx_data,
  input wire logic        tx_done,
  input wire logic        can_rst,
  input wire logic        msg_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmo_pkg::*;

  logic       take;
  logic [7:0] rst_len_r;

  assign take = cmd_valid && cmd_ready;

  // length of the controller reset pulse, cleared whenever it is low
  always_ff @(posedge clk) begin
    if (rst || !can_rst) begin
      rst_len_r <= 8'h00;
    end else begin
      rst_len_r <= rst_len_r + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_set_ans;
    take && cmd_op == OP_SET_REG |=> rsp_valid && rsp_data == 32'h0 ##1 cmd_ready;
  endproperty
  a_set_ans: assert property (p_set_ans) else $error("register write answer wrong");
  property p_reg_low;
    take && cmd_op == OP_GET_REG |=> rsp_valid && rsp_data[31:8] == 24'h0 && cmd_ready;
  endproperty
  a_reg_low: assert property (p_reg_low) else $error("register read not in low byte");
  property p_bad_read;
    take && cmd_op == OP_READ && cmd_obj == 4'h0 |=> rsp_valid && rsp_data == NO_MSG;
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("empty read answer wrong");
  property p_init_rst;
    take && cmd_op == OP_INIT |=> can_rst && !rsp_valid;
  endproperty
  a_init_rst: assert property (p_init_rst) else $error("init did not start with reset");
  property p_init_done;
    take && cmd_op == OP_INIT |=> (!rsp_valid && !cmd_ready)[*8] ##[190:210] rsp_valid;
  endproperty
  a_init_done: assert property (p_init_done) else $error("init answer timing wrong");
  property p_rst_len;
    $fell(can_rst) && !$past(rst) |-> rst_len_r >= 8'hC8 && rst_len_r <= 8'hD1;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("controller reset pulse length wrong");
  property p_evt_cause;
    msg_event |-> $past(rx_valid);
  endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without a frame");
  property p_tx_hold;
    tx_req && !tx_done |=> tx_req && $stable(tx_id) && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("pending frame changed");
  property p_tx_end;
    tx_req && tx_done |=> !tx_req;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("request stayed after done");
  property p_std_id;
    tx_req && !tx_ext |-> tx_id[28:11] == 18'h0;
  endproperty
  a_std_id: assert property (p_std_id) else $error("standard identifier too wide");

  c_init: cover property (take && cmd_op == OP_INIT);
  c_evt: cover property (msg_event);
  c_tx: cover property (tx_req && tx_done);
endmodule

bind cmo_access cmo_access_chk i_cmo_access_chk (.*);

// ---- testbench/cmo_can_node.sv ----
// ============
// other bus nodes: source of frames, acknowledge of sent frames
// ============
module cmo_can_node (
  // clock
  input wire logic         clk,
  // frames toward the block
  output logic             rx_valid,
  output logic [28:0]      rx_id,
  output logic             rx_ext,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data,
  // frames from the block
  input wire logic         tx_req,
  input wire logic [3:0]   tx_obj,
  input wire logic [28:0]  tx_id,
  input wire logic         tx_ext,
  input wire logic [3:0]   tx_dlc,
  input wire logic [63:0]  tx_data,
  output logic             tx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned slow = 0;
  int unsigned tx_cnt = 0;
  logic [3:0]  got_obj;
  logic [28:0] got_id;
  logic        got_ext;
  logic [3:0]  got_dlc;
  logic [63:0] got_data;

  initial begin
    rx_valid = 1'b0;
    rx_id = 29'h0;
    rx_ext = 1'b0;
    rx_dlc = 4'h0;
    rx_data = 64'h0;
    tx_done = 1'b0;
  end

  // one frame pulse; released lines show the inverse, never the old frame
  task automatic send(input logic [28:0] id, input logic ext, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_ext <= ext;
    rx_dlc <= dlc;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_ext <= ~ext;
    rx_dlc <= ~dlc;
    rx_data <= ~d;
  endtask

  // arbitration won promptly or after slow cycles
  always begin
    @(posedge clk);
    if (tx_req === 1'b1) begin
      got_obj = tx_obj;
      got_id = tx_id;
      got_ext = tx_ext;
      got_dlc = tx_dlc;
      got_data = tx_data;
      repeat (slow) @(posedge clk);
      tx_done <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
      tx_cnt++;
    end
  end
endmodule

// ---- testbench/cmo_access_tb.sv ----
// ============
// testbench of the message object access block
// ============
module cmo_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmo_pkg::*;

  localparam logic [63:0] D1 = 64'hF1E2D3C4B5A69788;
  localparam logic [63:0] D2 = 64'h0123456789ABCDEF;
  localparam logic [63:0] D3 = 64'h5A5A5A5AA5A5A5A5;

  logic        clk, rst, cmd_valid, cmd_ready, identifier_length_select, rsp_valid, buf_wr;
  logic        msg_valid, msg_ready, rx_valid, rx_ext, tx_req, tx_ext, tx_done, can_rst, msg_event;
  cmo_op_t     cmd_op;
  logic [3:0]  cmd_obj, buf_idx, rx_dlc, tx_obj, tx_dlc;
  logic [28:0] cmd_id, rx_id, tx_id;
  logic [7:0]  cmd_reg, cmd_wdata, buf_wdata, msg_data;
  logic [31:0] rsp_data, rsp;
  logic [63:0] rx_data, tx_data;
  logic [7:0]  q[$];
  int          failures = 0;
  int          cmp_count = 0;
  int          ev_cnt = 0;
  int          n;

  cmo_access i_cmo_access (.*);
  cmo_can_node i_cmo_can_node (.*);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // byte stream and event taps
  always @(posedge clk) begin
    if (msg_valid === 1'b1 && msg_ready === 1'b1) q.push_back(msg_data);
    if (msg_event === 1'b1) ev_cnt++;
  end

  task automatic ck(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one command, held until taken, answer captured in rsp
  task automatic cmd(input cmo_op_t op, input logic [3:0] obj = 4'h0, input logic [28:0] id = 29'h0,
                     input logic x = 1'b0, input logic [7:0] rg = 8'h00, input logic [7:0] wd = 8'h00);
    int k;
    k = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_obj <= obj;
    cmd_id <= id;
    identifier_length_select <= x;
    cmd_reg <= rg;
    cmd_wdata <= wd;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    rsp = rsp_data;
  endtask

  // fill the nine host buffer elements in one burst
  task automatic wbuf(input logic [63:0] d, input logic [7:0] cnt);
    for (int i = 1; i <= 9; i++) begin
      @(posedge clk);
      buf_wr <= 1'b1;
      buf_idx <= 4'(i);
      buf_wdata <= (i == 9) ? cnt : d[8*i-8 +: 8];
    end
    @(posedge clk);
    buf_wr <= 1'b0;
  endtask

  // read a fresh frame and compare answer and byte stream
  task automatic rd(input cmo_op_t op, input logic [3:0] obj, input logic [28:0] id,
                    input logic [3:0] dlc, input logic [63:0] d);
    int k;
    k = 0;
    q.delete();
    cmd(op, obj);
    ck("read id", {3'h0, id}, rsp);
    while (q.size() < 9 && k < 60) begin
      @(posedge clk);
      k++;
    end
    for (int i = 0; i < 8; i++) ck("read byte", d[8*i +: 8], q[i]);
    ck("byte count", dlc, q[8]);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_EN_RX;
    cmd_obj = 4'h0;
    cmd_id = 29'h0;
    identifier_length_select = 1'b0;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    buf_wr = 1'b0;
    buf_idx = 4'h0;
    buf_wdata = 8'h00;
    msg_ready = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cmd(OP_INIT);
    ck("init answer", 32'h0, rsp);
    for (int i = 0; i < CFG_N; i++) begin
      cmd(OP_GET_REG, 4'h0, 29'h0, 1'b0, CFG_ADDR[i]);
      ck("init register", {24'h0, CFG_DATA[i]}, rsp);
    end
    cmd(OP_SET_REG, 4'h0, 29'h0, 1'b0, 8'hFF, 8'hA5);
    cmd(OP_GET_REG, 4'h0, 29'h0, 1'b0, 8'hFF);
    ck("register 255", 32'h000000A5, rsp);
    i_cmo_can_node.send(29'h0, 1'b0, 4'h1, D1);
    cmd(OP_READ, 4'h1);
    ck("disabled object", NO_MSG, rsp);
    $display("test init done");
    cmd(OP_EN_RX, 4'hF, 29'h155);
    cmd(OP_EN_EVT, 4'hF);
    i_cmo_can_node.send(29'h154, 1'b0, 4'h8, D1);
    i_cmo_can_node.send(29'h155, 1'b1, 4'h8, D1);
    cmd(OP_READ, 4'hF);
    ck("filtered read", NO_MSG, rsp);
    ck("no event", 0, ev_cnt);
    i_cmo_can_node.send(29'h155, 1'b0, 4'h8, D1);
    rd(OP_READ, 4'hF, 29'h155, 4'h8, D1);
    ck("one event", 1, ev_cnt);
    cmd(OP_READ, 4'hF);
    ck("second read", NO_MSG, rsp);
    cmd(OP_READ, 4'h0);
    ck("object 0 read", NO_MSG, rsp);
    $display("test receive done");
    cmd(OP_EN_RX, 4'h2, 29'h1ABCDEF1, 1'b1);
    i_cmo_can_node.send(29'h0ABCDEF1, 1'b1, 4'h3, D2);
    cmd(OP_READ, 4'h2);
    ck("top bit differs", NO_MSG, rsp);
    i_cmo_can_node.send(29'h1ABCDEF1, 1'b1, 4'h3, D2);
    msg_ready <= 1'b0;
    fork
      rd(OP_READ_CON, 4'h2, 29'h1ABCDEF1, 4'h3, D2);
      begin
        repeat (3) @(posedge clk);
        i_cmo_can_node.send(29'h1ABCDEF1, 1'b1, 4'h5, D3);
      end
      begin
        repeat (20) @(posedge clk);
        msg_ready <= 1'b1;
      end
    join
    rd(OP_READ, 4'h2, 29'h1ABCDEF1, 4'h5, D3);
    ck("event count", 1, ev_cnt);
    $display("test extended done");
    cmd(OP_EN_TX, 4'hE, 29'h1FFFFFFF, 1'b0);
    cmd(OP_EN_TX, 4'hF, 29'h12, 1'b0);
    wbuf(D1, 8'h03);
    cmd(OP_TRANSMIT, 4'hF);
    cmd(OP_TRANSMIT, 4'hD);
    cmd(OP_TRANSMIT, 4'hE);
    n = 0;
    while (i_cmo_can_node.tx_cnt < 1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    ck("sent object", 4'hE, i_cmo_can_node.got_obj);
    ck("sent id", 29'h7FF, i_cmo_can_node.got_id);
    ck("sent length", 4'h3, i_cmo_can_node.got_dlc);
    ck("sent data", D1[23:0], i_cmo_can_node.got_data[23:0]);
    i_cmo_can_node.slow = 30;
    cmd(OP_EN_TX, 4'h1, 29'h1ABCDEF1, 1'b1);
    cmd(OP_TRANSMIT, 4'h1);
    repeat (60) @(posedge clk);
    ck("frames sent", 2, i_cmo_can_node.tx_cnt);
    ck("extended id", 29'h1ABCDEF1, i_cmo_can_node.got_id);
    ck("extended flag", 1'b1, i_cmo_can_node.got_ext);
    $display("test transmit done");
    summarize();
  end
endmodule
